//--- hdl/rtv_pkg.sv
package rtv_pkg;

    // ==========================================================
    // register word indices (byte address is four times these)
    localparam logic [3:0] RTV_IDX_CAL_YM = 4'h0;
    localparam logic [3:0] RTV_IDX_ALM_SEC = 4'h1;
    localparam logic [3:0] RTV_IDX_ALM_HM = 4'h2;
    localparam logic [3:0] RTV_IDX_ALM_DW = 4'h3;
    localparam logic [3:0] RTV_IDX_ALM_YM = 4'h4;
    localparam logic [3:0] RTV_IDX_TS_SEC = 4'h5;
    localparam logic [3:0] RTV_IDX_TS_HM = 4'h6;
    localparam logic [3:0] RTV_IDX_CTRL = 4'h7;
    localparam logic [3:0] RTV_IDX_STAT = 4'h8;
    localparam logic [3:0] RTV_IDX_IMASK = 4'h9;

    // ==========================================================
    // implemented-bit masks of the value registers
    localparam logic [15:0] RTV_MASK_YM = 16'hFF1F;
    localparam logic [15:0] RTV_MASK_SEC = 16'h7F00;
    localparam logic [15:0] RTV_MASK_HM = 16'h3F7F;
    localparam logic [15:0] RTV_MASK_DW = 16'h3F07;
    localparam logic [15:0] RTV_MASK_FULL = 16'hFFFF;
    localparam logic [15:0] RTV_MASK_CTRL = 16'h8F01;
    localparam logic [15:0] RTV_MASK_STAT = 16'h0028;

    // ==========================================================
    // field positions
    localparam int RTV_YR_TENS_LSB = 12;
    localparam int RTV_YR_UNITS_LSB = 8;
    localparam int RTV_MTH_TENS_BIT = 4;
    localparam int RTV_MTH_UNITS_LSB = 0;
    localparam int RTV_HI_TENS_LSB = 12;
    localparam int RTV_HI_UNITS_LSB = 8;
    localparam int RTV_LO_TENS_LSB = 4;
    localparam int RTV_LO_UNITS_LSB = 0;
    localparam int RTV_WEEKDAY_VALUE_LSB = 0;

    // control register fields
    localparam int RTV_CTRL_STAMP_EN = 0;
    localparam int RTV_CTRL_SOFT_STAMP = 1;
    localparam int RTV_CTRL_MATCH_LSB = 8;
    localparam int RTV_CTRL_ALARM_EN = 15;

    // status / interrupt mask fields
    localparam int RTV_STAT_STAMP = 3;
    localparam int RTV_STAT_ALARM = 5;

    // ==========================================================
    // reset values
    localparam logic [15:0] RTV_RST_ZERO = 16'h0000;
    localparam logic [3:0] RTV_RST_YR_TENS = 4'h0;
    localparam logic [31:0] RTV_RST_RDATA = 32'h0000_0000;

    // ==========================================================
    // alarm match selections
    typedef enum logic [3:0] {
        RTV_MS_HALF_SEC = 4'b0000,
        RTV_MS_SECOND = 4'b0001,
        RTV_MS_TEN_SEC = 4'b0010,
        RTV_MS_MINUTE = 4'b0011,
        RTV_MS_TEN_MIN = 4'b0100,
        RTV_MS_HOUR = 4'b0101,
        RTV_MS_DAY = 4'b0110,
        RTV_MS_WEEK = 4'b0111,
        RTV_MS_MONTH = 4'b1000,
        RTV_MS_YEAR = 4'b1001
    } rtv_match_t;

endpackage

//--- hdl/rtv_value_regs.sv
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps

// Contract
// - the year is stored as two bcd digits, tens in bits 15-12 and units in bits 11-8.
// - the month tens digit is one bit at position 4 and can only be zero or one.
// - the month units digit is a four-bit bcd value in bits 3-0.
// - seconds hold tens in bits 14-12 (0 to 5) and units in bits 11-8 (0 to 9).
// - hours hold tens in bits 13-12 (0 to 2) and units in bits 11-8 (0 to 9).
// - minutes hold tens in bits 6-4 (0 to 5) and units in bits 3-0.
// - the alarm day of month holds tens in bits 13-12 (0 to 3) and units in bits 11-8.
// - the alarm weekday is a three-bit value in bits 2-0, from 0 to 6.
// - unimplemented bits read as zero and ignore writes.
// - while stamping is disabled, all sixteen stamp bits are storage that survives non-power-on resets.
// - the alarm fires when the digits chosen by the match select equal the alarm registers.
// - software may trigger a stamp; captured values are valid once the stamp flag reads set.
module rtv_value_regs
    import rtv_pkg::*;
(
    // clock and resets
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic external_reset_pin,
    input wire logic watchdog_reset,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // live clock digits from the counter chain
    input wire logic half_sec_tick,
    input wire logic second_half,
    input wire logic [6:0] live_seconds,
    input wire logic [6:0] live_minutes,
    input wire logic [5:0] live_hours,
    input wire logic [5:0] live_day,
    input wire logic [2:0] weekday_value,
    // events
    input wire logic stamp_event_in,
    output logic alarm_pulse,
    output logic irq
);
    import rtv_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [15:0] cal_ym;
        logic [15:0] alm_sec;
        logic [15:0] alm_hm;
        logic [15:0] alm_dw;
        logic [15:0] alm_ym;
        logic [15:0] ts_sec;
        logic [15:0] ts_hm;
        logic [15:0] ctrl;
        logic [15:0] stat;
        logic [15:0] imask;
        logic [31:0] rdata;
        logic wait_n;
        logic alarm;
        logic irq;
    } rtv_state_t;

    rtv_state_t state_q;
    rtv_state_t state_d;

    // ==========================================================
    // helpers

    // merge the two low byte lanes into a register, then drop unimplemented bits
    function automatic logic [15:0] rtv_merge(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0] be,
        input logic [15:0] mask
    );
        logic [15:0] v;
        v = old;
        if (be[0])
        begin
            v[7:0] = data[7:0];
        end
        if (be[1])
        begin
            v[15:8] = data[15:8];
        end
        return v & mask;
    endfunction

    // high-byte digit pair (tens at 15-12 / 13-12 / 14-12, units at 11-8)
    function automatic logic [7:0] rtv_hi_pair(input logic [15:0] r);
        return r[15:8];
    endfunction

    // ==========================================================
    // decode and alarm match
    logic req;
    logic commit;
    logic stamp_en;
    logic [3:0] match_sel;
    logic sec_eq;
    logic sec_units_eq;
    logic min_eq;
    logic min_units_eq;
    logic hr_eq;
    logic weekday_value_eq;
    logic day_eq;
    logic mth_eq;
    logic digits_hit;
    logic alarm_hit;
    logic soft_stamp;
    logic stamp_hit;
    logic [15:0] live_sec_word;
    logic [15:0] live_hm_word;
    logic [15:0] ts_mask;
    logic [15:0] rd_word;
    logic [15:0] stat_w1c;

    always_comb
    begin
        req = read | write;
        // first edge of a request answers, second edge (waitrequest low) commits
        commit = req & ~state_q.wait_n;
        stamp_en = state_q.ctrl[RTV_CTRL_STAMP_EN];
        match_sel = state_q.ctrl[RTV_CTRL_MATCH_LSB +: 4];
        // live digits packed into the register layout
        live_sec_word = {1'b0, live_seconds, 8'h00};
        live_hm_word = {2'b00, live_hours, 1'b0, live_minutes};
        // stamp registers are plain storage while capture is off
        ts_mask = stamp_en ? RTV_MASK_HM : RTV_MASK_FULL;
    end

    always_comb
    begin
        sec_units_eq = live_seconds[3:0] == state_q.alm_sec[RTV_HI_UNITS_LSB +: 4];
        sec_eq = {1'b0, live_seconds} == rtv_hi_pair(state_q.alm_sec);
        min_units_eq = live_minutes[3:0] == state_q.alm_hm[RTV_LO_UNITS_LSB +: 4];
        min_eq = live_minutes == state_q.alm_hm[6:0];
        hr_eq = {2'b00, live_hours} == rtv_hi_pair(state_q.alm_hm);
        weekday_value_eq = weekday_value == state_q.alm_dw[RTV_WEEKDAY_VALUE_LSB +: 3];
        day_eq = {2'b00, live_day} == rtv_hi_pair(state_q.alm_dw);
        mth_eq = state_q.cal_ym[4:0] == state_q.alm_ym[4:0];
        // each wider selection adds digits on top of the one before, but month compares the day of month instead of the weekday
        case (match_sel)
            RTV_MS_SECOND: digits_hit = 1'b1;
            RTV_MS_TEN_SEC: digits_hit = sec_units_eq;
            RTV_MS_MINUTE: digits_hit = sec_eq;
            RTV_MS_TEN_MIN: digits_hit = sec_eq & min_units_eq;
            RTV_MS_HOUR: digits_hit = sec_eq & min_eq;
            RTV_MS_DAY: digits_hit = sec_eq & min_eq & hr_eq;
            RTV_MS_WEEK: digits_hit = sec_eq & min_eq & hr_eq & weekday_value_eq;
            RTV_MS_MONTH: digits_hit = sec_eq & min_eq & hr_eq & day_eq;
            RTV_MS_YEAR: digits_hit = sec_eq & min_eq & hr_eq & day_eq & mth_eq;
            default: digits_hit = 1'b0;
        endcase
        // whole-second selections fire only at the start of a second
        if (match_sel == RTV_MS_HALF_SEC)
        begin
            alarm_hit = half_sec_tick;
        end
        else
        begin
            alarm_hit = half_sec_tick & ~second_half & digits_hit;
        end
        alarm_hit = alarm_hit & state_q.ctrl[RTV_CTRL_ALARM_EN];
    end

    // ==========================================================
    // stamp trigger and read mux
    always_comb
    begin
        soft_stamp = 1'b0;
        if (commit && write && address == RTV_IDX_CTRL && byteenable[0])
        begin
            soft_stamp = writedata[RTV_CTRL_SOFT_STAMP];
        end
        stamp_hit = stamp_en & (stamp_event_in | soft_stamp);
        stat_w1c = RTV_RST_ZERO;
        if (commit && write && address == RTV_IDX_STAT)
        begin
            stat_w1c = rtv_merge(RTV_RST_ZERO, writedata, byteenable, RTV_MASK_STAT);
        end
        // only implemented bits are ever stored, so reads return zeros elsewhere
        if (address == RTV_IDX_CAL_YM)
        begin
            rd_word = state_q.cal_ym;
        end
        else if (address == RTV_IDX_ALM_SEC)
        begin
            rd_word = state_q.alm_sec;
        end
        else if (address == RTV_IDX_ALM_HM)
        begin
            rd_word = state_q.alm_hm;
        end
        else if (address == RTV_IDX_ALM_DW)
        begin
            rd_word = state_q.alm_dw;
        end
        else if (address == RTV_IDX_ALM_YM)
        begin
            rd_word = state_q.alm_ym;
        end
        else if (address == RTV_IDX_TS_SEC)
        begin
            rd_word = state_q.ts_sec;
        end
        else if (address == RTV_IDX_TS_HM)
        begin
            rd_word = state_q.ts_hm;
        end
        else if (address == RTV_IDX_CTRL)
        begin
            rd_word = state_q.ctrl;
        end
        else if (address == RTV_IDX_STAT)
        begin
            rd_word = state_q.stat;
        end
        else if (address == RTV_IDX_IMASK)
        begin
            rd_word = state_q.imask;
        end
        else
        begin
            rd_word = RTV_RST_ZERO;
        end
    end

    // ==========================================================
    // next state
    always_comb
    begin
        state_d = state_q;
        state_d.alarm = alarm_hit;

        // bus handshake: waitrequest drops for one cycle after the request is seen
        if (req && state_q.wait_n)
        begin
            state_d.wait_n = 1'b0;
            state_d.rdata = read ? {16'h0000, rd_word} : RTV_RST_RDATA;
        end
        else
        begin
            state_d.wait_n = 1'b1;
        end

        if (commit && write)
        begin
            if (address == RTV_IDX_CAL_YM)
            begin
                state_d.cal_ym = rtv_merge(state_q.cal_ym, writedata, byteenable, RTV_MASK_YM);
            end
            else if (address == RTV_IDX_ALM_SEC)
            begin
                state_d.alm_sec = rtv_merge(state_q.alm_sec, writedata, byteenable, RTV_MASK_SEC);
            end
            else if (address == RTV_IDX_ALM_HM)
            begin
                state_d.alm_hm = rtv_merge(state_q.alm_hm, writedata, byteenable, RTV_MASK_HM);
            end
            else if (address == RTV_IDX_ALM_DW)
            begin
                state_d.alm_dw = rtv_merge(state_q.alm_dw, writedata, byteenable, RTV_MASK_DW);
            end
            else if (address == RTV_IDX_ALM_YM)
            begin
                state_d.alm_ym = rtv_merge(state_q.alm_ym, writedata, byteenable, RTV_MASK_YM);
            end
            else if (address == RTV_IDX_TS_SEC)
            begin
                state_d.ts_sec = rtv_merge(state_q.ts_sec, writedata, byteenable,
                                           stamp_en ? RTV_MASK_SEC : RTV_MASK_FULL);
            end
            else if (address == RTV_IDX_TS_HM)
            begin
                state_d.ts_hm = rtv_merge(state_q.ts_hm, writedata, byteenable, ts_mask);
            end
            else if (address == RTV_IDX_CTRL)
            begin
                // the soft stamp bit is a strobe and never stored
                state_d.ctrl = rtv_merge(state_q.ctrl, writedata, byteenable, RTV_MASK_CTRL);
            end
            else if (address == RTV_IDX_IMASK)
            begin
                state_d.imask = rtv_merge(state_q.imask, writedata, byteenable, RTV_MASK_STAT);
            end
        end

        // a hardware capture in the same cycle as a bus write wins
        if (stamp_hit)
        begin
            state_d.ts_sec = live_sec_word & RTV_MASK_SEC;
            state_d.ts_hm = live_hm_word & RTV_MASK_HM;
        end

        // sticky flags: set beats write-one-to-clear
        state_d.stat = (state_q.stat & ~stat_w1c) & RTV_MASK_STAT;
        if (stamp_hit)
        begin
            state_d.stat[RTV_STAT_STAMP] = 1'b1;
        end
        if (alarm_hit)
        begin
            state_d.stat[RTV_STAT_ALARM] = 1'b1;
        end
        state_d.irq = |(state_d.stat & state_d.imask);

        // non-power-on reset: alarm and control go back, stamps survive while disabled
        if (external_reset_pin || watchdog_reset)
        begin
            state_d.alm_sec = RTV_RST_ZERO;
            state_d.alm_hm = RTV_RST_ZERO;
            state_d.alm_dw = RTV_RST_ZERO;
            state_d.alm_ym = RTV_RST_ZERO;
            state_d.ctrl = RTV_RST_ZERO;
            state_d.stat = RTV_RST_ZERO;
            state_d.imask = RTV_RST_ZERO;
            state_d.rdata = RTV_RST_RDATA;
            state_d.wait_n = 1'b1;
            state_d.alarm = 1'b0;
            state_d.irq = 1'b0;
            if (stamp_en)
            begin
                state_d.ts_sec = RTV_RST_ZERO;
                state_d.ts_hm = RTV_RST_ZERO;
            end
            else
            begin
                state_d.ts_sec = state_q.ts_sec;
                state_d.ts_hm = state_q.ts_hm;
            end
        end

        // power-on reset clears everything except the live year units and month
        if (rst)
        begin
            // unimplemented bits are forced low even though the digits stay unloaded
            state_d.cal_ym = state_q.cal_ym & RTV_MASK_YM;
            state_d.cal_ym[RTV_YR_TENS_LSB +: 4] = RTV_RST_YR_TENS;
            state_d.alm_sec = RTV_RST_ZERO;
            state_d.alm_hm = RTV_RST_ZERO;
            state_d.alm_dw = RTV_RST_ZERO;
            state_d.alm_ym = RTV_RST_ZERO;
            state_d.ts_sec = RTV_RST_ZERO;
            state_d.ts_hm = RTV_RST_ZERO;
            state_d.ctrl = RTV_RST_ZERO;
            state_d.stat = RTV_RST_ZERO;
            state_d.imask = RTV_RST_ZERO;
            state_d.rdata = RTV_RST_RDATA;
            state_d.wait_n = 1'b1;
            state_d.alarm = 1'b0;
            state_d.irq = 1'b0;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge ref_clk)
    begin
        state_q <= state_d;
    end

    // ==========================================================
    // outputs, straight from the state flops
    assign readdata = state_q.rdata;
    assign waitrequest = state_q.wait_n;
    assign alarm_pulse = state_q.alarm;
    assign irq = state_q.irq;

endmodule // rtv_value_regs

//--- tb/rtv_value_regs_chk.sv
`timescale 1ns/1ps
// ==========================================================
// port-level relations of the value register block
module rtv_value_regs_chk
    import rtv_pkg::*;
(
    // clock and resets
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic external_reset_pin,
    input wire logic watchdog_reset,
    // register bus
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // events
    input wire logic half_sec_tick,
    input wire logic alarm_pulse,
    input wire logic irq
);
    import rtv_pkg::*;
    logic [15:0] imp_mask;
    logic [15:0] mask_q;
    // stamp words may hold all bits while stamping is off, so they get the full mask
    always_comb
    begin
        case (address)
            RTV_IDX_CAL_YM, RTV_IDX_ALM_YM: imp_mask = RTV_MASK_YM;
            RTV_IDX_ALM_SEC: imp_mask = RTV_MASK_SEC;
            RTV_IDX_ALM_HM: imp_mask = RTV_MASK_HM;
            RTV_IDX_ALM_DW: imp_mask = RTV_MASK_DW;
            RTV_IDX_TS_SEC, RTV_IDX_TS_HM: imp_mask = RTV_MASK_FULL;
            RTV_IDX_CTRL: imp_mask = RTV_MASK_CTRL;
            RTV_IDX_STAT, RTV_IDX_IMASK: imp_mask = RTV_MASK_STAT;
            default: imp_mask = RTV_RST_ZERO;
        endcase
    end
    always_ff @(posedge ref_clk)
        mask_q <= imp_mask;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst || external_reset_pin || watchdog_reset);

    sequence req_taken_s;
        (read || write) && waitrequest;
    endsequence
    sequence answer_s;
        !waitrequest ##1 waitrequest;
    endsequence

    bus_handshake_a: assert property (req_taken_s |=> answer_s)
        else $error("request not answered for exactly one cycle");
    wait_cause_a: assert property ($fell(waitrequest) |-> $past(read || write))
        else $error("answer without a request");
    upper_zero_a: assert property (!waitrequest |-> readdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    unimpl_zero_a: assert property (read && waitrequest |=> (readdata[15:0] & ~mask_q) == 16'h0000)
        else $error("unimplemented bit read as one");
    rdata_hold_a: assert property (!waitrequest |=> $stable(readdata))
        else $error("read data changed after the answer");
    alarm_tick_a: assert property (alarm_pulse |-> $past(half_sec_tick))
        else $error("alarm pulse without a tick");
    alarm_single_a: assert property (alarm_pulse |=> !alarm_pulse)
        else $error("alarm pulse longer than one cycle");
    soft_reset_a: assert property (disable iff (rst) (external_reset_pin || watchdog_reset) |=>
        !irq && !alarm_pulse && waitrequest) else $error("outputs not cleared by reset");
endmodule // rtv_value_regs_chk

bind rtv_value_regs rtv_value_regs_chk u_chk (.ref_clk(ref_clk), .rst(rst),
    .external_reset_pin(external_reset_pin), .watchdog_reset(watchdog_reset), .address(address),
    .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .half_sec_tick(half_sec_tick), .alarm_pulse(alarm_pulse), .irq(irq));

//--- tb/test_rtc_alarm_timestamp_regs.sv
`timescale 1ns/1ps
module test_rtc_alarm_timestamp_regs;
    import rtv_pkg::*;
    logic ref_clk, rst, external_reset_pin, watchdog_reset, read, write, waitrequest;
    logic [3:0] address, byteenable;
    logic [31:0] writedata, readdata;
    logic half_sec_tick, second_half, stamp_event_in, alarm_pulse, irq;
    logic [6:0] live_seconds, live_minutes;
    logic [5:0] live_hours, live_day;
    logic [2:0] weekday_value;
    logic [15:0] rd;
    int failures, checked;

    rtv_value_regs u_dut (.ref_clk(ref_clk), .rst(rst), .external_reset_pin(external_reset_pin),
        .watchdog_reset(watchdog_reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .half_sec_tick(half_sec_tick), .second_half(second_half), .live_seconds(live_seconds),
        .live_minutes(live_minutes), .live_hours(live_hours), .live_day(live_day),
        .weekday_value(weekday_value), .stamp_event_in(stamp_event_in), .alarm_pulse(alarm_pulse), .irq(irq));

    // ==========================================================
    // shared tasks
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // request held until waitrequest is sampled low, then released
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [15:0] data, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge ref_clk);
        address <= idx;
        read <= !wr;
        write <= wr;
        writedata <= {16'h0000, data};
        byteenable <= be;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 20);
        check("waitrequest", 16'h0000, {15'h0000, waitrequest});
        rd = readdata[15:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [3:0] idx, input logic [15:0] exp);
        bus(1'b0, idx, 16'h0000, 4'hF);
        check(name, exp, rd);
    endtask

    task automatic pulse(input logic wdt, input logic evt);
        @(posedge ref_clk);
        external_reset_pin <= !wdt && !evt;
        watchdog_reset <= wdt;
        stamp_event_in <= evt;
        @(posedge ref_clk);
        external_reset_pin <= 1'b0;
        watchdog_reset <= 1'b0;
        stamp_event_in <= 1'b0;
    endtask

    task automatic ticks(input logic [6:0] sec, input logic [15:0] exp);
        logic [15:0] n;
        n = 16'h0000;
        @(posedge ref_clk);
        live_seconds <= sec;
        // both halves of the second, since the designer picks the half that fires
        for (int h = 0; h < 2; h++)
        begin
            @(posedge ref_clk);
            second_half <= h[0];
            half_sec_tick <= 1'b1;
            @(posedge ref_clk);
            half_sec_tick <= 1'b0;
            repeat (3)
            begin
                @(posedge ref_clk);
                n = n + {15'h0000, alarm_pulse === 1'b1};
            end
        end
        check("alarm pulses", exp, n);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        for (int i = 1; i < 10; i++)
            rd_chk("reset value", 4'(i), 16'h0000);
        bus(1'b0, RTV_IDX_CAL_YM, 16'h0000, 4'hF);
        check("year_tens_digit", 16'h0000, {12'h000, rd[15:12]});
        $display("test reset done");
    endtask

    task automatic t_fields;
        logic [15:0] m [7];
        m = '{RTV_MASK_YM, RTV_MASK_SEC, RTV_MASK_HM, RTV_MASK_DW, RTV_MASK_YM, RTV_MASK_FULL, RTV_MASK_FULL};
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b1, 4'(i), 16'hFFFF, 4'hF);
            rd_chk("field mask", 4'(i), m[i]);
        end
        bus(1'b1, RTV_IDX_ALM_HM, 16'h2359, 4'hF);
        rd_chk("alarm_hours_minutes", RTV_IDX_ALM_HM, 16'h2359);
        bus(1'b1, RTV_IDX_ALM_HM, 16'h0000, 4'h1);
        rd_chk("low lane only", RTV_IDX_ALM_HM, 16'h2300);
        bus(1'b1, RTV_IDX_ALM_DW, 16'h3106, 4'hF);
        rd_chk("alarm_day_weekday", RTV_IDX_ALM_DW, 16'h3106);
        bus(1'b1, RTV_IDX_CAL_YM, 16'h9912, 4'hF);
        rd_chk("calendar_year_month", RTV_IDX_CAL_YM, 16'h9912);
        bus(1'b1, 4'hA, 16'hFFFF, 4'hF);
        rd_chk("unmapped", 4'hA, 16'h0000);
        $display("test fields done");
    endtask

    task automatic t_keep;
        bus(1'b1, RTV_IDX_TS_SEC, 16'hA5C3, 4'hF);
        bus(1'b1, RTV_IDX_TS_HM, 16'h5A3C, 4'hF);
        pulse(1'b0, 1'b0);
        rd_chk("stamp_seconds", RTV_IDX_TS_SEC, 16'hA5C3);
        rd_chk("alarm_hours_minutes", RTV_IDX_ALM_HM, 16'h0000);
        rd_chk("calendar_year_month", RTV_IDX_CAL_YM, 16'h9912);
        pulse(1'b1, 1'b0);
        rd_chk("stamp_hours_minutes", RTV_IDX_TS_HM, 16'h5A3C);
        $display("test keep done");
    endtask

    task automatic t_stamp;
        @(posedge ref_clk);
        live_seconds <= 7'h47;
        live_minutes <= 7'h38;
        live_hours <= 6'h23;
        bus(1'b1, RTV_IDX_CTRL, 16'h0001, 4'hF);
        bus(1'b1, RTV_IDX_IMASK, 16'h0008, 4'hF);
        pulse(1'b0, 1'b1);
        repeat (2) @(posedge ref_clk);
        check("irq", 16'h0001, {15'h0000, irq});
        rd_chk("stamp_seconds", RTV_IDX_TS_SEC, 16'h4700);
        rd_chk("stamp_hours_minutes", RTV_IDX_TS_HM, 16'h2338);
        rd_chk("stamp_event_flag", RTV_IDX_STAT, 16'h0008);
        bus(1'b1, RTV_IDX_STAT, 16'h0008, 4'hF);
        rd_chk("stamp_event_flag", RTV_IDX_STAT, 16'h0000);
        // irq is registered from the cleared next status, so it drops at the same edge as the commit
        @(posedge ref_clk);
        check("irq", 16'h0000, {15'h0000, irq});
        bus(1'b1, RTV_IDX_CTRL, 16'h0003, 4'hF);
        rd_chk("soft stamp flag", RTV_IDX_STAT, 16'h0008);
        rd_chk("control", RTV_IDX_CTRL, 16'h0001);
        bus(1'b1, RTV_IDX_STAT, 16'h0008, 4'hF);
        bus(1'b1, RTV_IDX_CTRL, 16'h0000, 4'hF);
        pulse(1'b0, 1'b1);
        rd_chk("flag while disabled", RTV_IDX_STAT, 16'h0000);
        rd_chk("stamp kept", RTV_IDX_TS_SEC, 16'h4700);
        bus(1'b1, RTV_IDX_CTRL, 16'h0001, 4'hF);
        pulse(1'b0, 1'b0);
        rd_chk("stamp cleared when enabled", RTV_IDX_TS_SEC, 16'h0000);
        $display("test stamp done");
    endtask

    task automatic t_alarm;
        @(posedge ref_clk);
        live_minutes <= 7'h38;
        live_hours <= 6'h23;
        live_day <= 6'h15;
        weekday_value <= 3'h3;
        bus(1'b1, RTV_IDX_ALM_SEC, 16'h2500, 4'hF);
        bus(1'b1, RTV_IDX_ALM_HM, 16'h2338, 4'hF);
        bus(1'b1, RTV_IDX_ALM_DW, 16'h1503, 4'hF);
        // month must equal the live calendar month for the yearly selection
        bus(1'b1, RTV_IDX_ALM_YM, 16'h2512, 4'hF);
        bus(1'b1, RTV_IDX_IMASK, 16'h0020, 4'hF);
        // every selection with all digits matching
        for (int i = 0; i < 10; i++)
        begin
            bus(1'b1, RTV_IDX_CTRL, {4'h8, 4'(i), 8'h00}, 4'hF);
            ticks(7'h25, (i == 0) ? 16'h0002 : 16'h0001);
        end
        check("irq", 16'h0001, {15'h0000, irq});
        rd_chk("alarm event", RTV_IDX_STAT, 16'h0020);
        bus(1'b1, RTV_IDX_CTRL, {4'h8, RTV_MS_TEN_SEC, 8'h00}, 4'hF);
        ticks(7'h35, 16'h0001);
        ticks(7'h24, 16'h0000);
        bus(1'b1, RTV_IDX_CTRL, {4'h8, RTV_MS_MINUTE, 8'h00}, 4'hF);
        ticks(7'h35, 16'h0000);
        $display("test alarm done");
    endtask

    // ==========================================================
    // run control
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // the run needs about 400 cycles; this allows twenty times that
    initial
    begin
        #200000;
        failures++;
        $display("Error watchdog expected done seen timeout");
        tally_and_finish;
    end

    initial
    begin
        {rst, external_reset_pin, watchdog_reset, read, write, address, writedata} = {1'b1, 40'h0};
        {byteenable, half_sec_tick, second_half, stamp_event_in} = {4'hF, 3'b000};
        {live_seconds, live_minutes, live_hours, live_day, weekday_value} = 29'h0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset;
        t_fields;
        t_keep;
        t_stamp;
        t_alarm;
        tally_and_finish;
    end
endmodule // test_rtc_alarm_timestamp_regs
